/* File: rtl/lpw_pkg.sv */
// package: constants and carrier types for the led pwm with watchdog
package lpw_pkg;
   localparam int LPW_DUTY_W = 8;
   localparam int LPW_PRE_W = 12;
   localparam int LPW_WDT_W = 8;
   localparam int LPW_CTRL_W = 2;
   // period of one pwm cycle in prescaler ticks
   localparam int LPW_PERIOD_TICKS = 256;
   localparam logic [7:0] LPW_WDT_RESET_LOAD = 8'h14;
   localparam logic [1:0] LPW_CTRL_FULL_ON = 2'h3;
   localparam logic [1:0] LPW_CTRL_OFF = 2'h0;
   localparam logic [1:0] LPW_CTRL_PWM = 2'h2;
   localparam logic [1:0] LPW_CTRL_ON_ALT = 2'h1;
   localparam int LPW_WDT_UNIT_MS = 200;
   localparam int LPW_TICK_HZ = 5;
   localparam int LPW_CLK_HZ = 25000000;

   typedef struct packed {
      logic [1:0] control;
      logic useMainClk;
      logic [11:0] prescale;
      logic [7:0] watchdog_reload_value;
   } lpw_cfg_s;

   typedef struct packed {
      logic cfgWrite;
      logic dutyWrite;
      logic [7:0] duty;
   } lpw_wr_s;
endpackage

/* File: rtl/lpw_prescale.sv */
// prescaler: one tick per (prescale+1) source edges
`timescale 1ns/10ps
module lpw_prescale
   import lpw_pkg::*;
#(
   parameter int PRE_W = LPW_PRE_W
) (
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic clkEn,
   input wire logic srcEdge,
   input wire logic [PRE_W-1:0] prescale,
   output logic tick
);
   logic [PRE_W-1:0] cnt;
   logic [PRE_W-1:0] next_cnt;
   logic next_tick;

   initial begin
      if (PRE_W < 1) begin
         $error("lpw_prescale: PRE_W must be positive");
      end
   end

   always_comb begin
      next_cnt = cnt;
      next_tick = 1'b0;
      if (srcEdge) begin
         if (cnt >= prescale) begin
            next_cnt = '0;
            next_tick = 1'b1;
         end else begin
            next_cnt = cnt + 1'b1;
         end
      end
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         cnt <= '0;
         tick <= 1'b0;
      end else if (clkEn) begin
         cnt <= next_cnt;
         tick <= next_tick;
      end
   end
endmodule // lpw_prescale

/* File: rtl/lpw_watchdog.sv */
// watchdog: 8-bit down counter ticked at 5 hz with reload
`timescale 1ns/10ps
module lpw_watchdog
   import lpw_pkg::*;
#(
   parameter int WDT_W = LPW_WDT_W
) (
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic clkEn,
   input wire logic active,
   input wire logic reload,
   input wire logic [WDT_W-1:0] reloadValue,
   input wire logic tick5,
   output logic [WDT_W-1:0] count,
   output logic terminal
);
   logic [WDT_W-1:0] next_count;
   logic next_terminal;

   initial begin
      if (WDT_W != LPW_WDT_W) begin
         $error("lpw_watchdog: counter must be 8 bits");
      end
   end

   always_comb begin
      next_count = count;
      next_terminal = 1'b0;
      if (reload) begin
         next_count = reloadValue;
      end else if (active && tick5 && count != '0) begin
         next_count = count - 1'b1;
         next_terminal = (count == WDT_W'(1));
      end
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         count <= LPW_WDT_RESET_LOAD;
         terminal <= 1'b0;
      end else if (clkEn) begin
         count <= next_count;
         terminal <= next_terminal;
      end
   end
endmodule // lpw_watchdog

/* File: rtl/lpw_top.sv */
// top: led pwm / blink generator with general-purpose mode watchdog
`timescale 1ns/10ps
module lpw_top
   import lpw_pkg::*;
#(
   parameter int PRE_W = LPW_PRE_W
) (
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic clkEn,
   input wire logic mainClkEdge,
   input wire logic slowClkPin,
   input wire logic tick5Pin,
   input wire lpw_cfg_s cfgIn,
   input wire lpw_wr_s wrIn,
   output lpw_cfg_s cfgOut,
   output logic [LPW_DUTY_W-1:0] duty,
   output logic [LPW_WDT_W-1:0] wdtCount,
   output logic wdtIrq,
   output logic pwmOut
);
   localparam int UNIT_MS = LPW_WDT_UNIT_MS;
   localparam int TICK_PERIOD_MS = 1000 / LPW_TICK_HZ;

   initial begin
      if (PRE_W != LPW_PRE_W || TICK_PERIOD_MS != UNIT_MS) begin
         $error("lpw_top: unsupported prescale width or tick period");
      end
   end

   // two-stage synchronisers for the pin-side clocks
   logic slowS1;
   logic slowS2;
   logic slowS3;
   logic tickS1;
   logic tickS2;
   logic tickS3;
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         slowS1 <= 1'b0;
         slowS2 <= 1'b0;
         slowS3 <= 1'b0;
         tickS1 <= 1'b0;
         tickS2 <= 1'b0;
         tickS3 <= 1'b0;
      end else if (clkEn) begin
         slowS1 <= slowClkPin;
         slowS2 <= slowS1;
         slowS3 <= slowS2;
         tickS1 <= tick5Pin;
         tickS2 <= tickS1;
         tickS3 <= tickS2;
      end
   end

   logic slowEdge;
   logic tick5;
   assign slowEdge = slowS2 & ~slowS3;
   // a stopped 5 hz clock simply produces no edges, so the counter holds
   assign tick5 = tickS2 & ~tickS3;

   // configuration and duty registers
   lpw_cfg_s cfg;
   lpw_cfg_s next_cfg;
   logic [LPW_DUTY_W-1:0] next_duty;
   logic wdtTerminal;
   logic wdtActive;

   assign wdtActive = cfg.useMainClk && cfg.watchdog_reload_value != '0;

   always_comb begin
      next_cfg = cfg;
      next_duty = duty;
      if (wrIn.cfgWrite) begin
         next_cfg = cfgIn;
      end
      if (wrIn.dutyWrite) begin
         next_duty = wrIn.duty;
      end
      // hardware forcing wins over a simultaneous software write
      if (wdtTerminal) begin
         next_cfg.control = LPW_CTRL_FULL_ON;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         cfg <= '{control: LPW_CTRL_OFF, useMainClk: 1'b0, prescale: '0,
                  watchdog_reload_value: LPW_WDT_RESET_LOAD};
         duty <= '0;
      end else if (clkEn) begin
         cfg <= next_cfg;
         duty <= next_duty;
      end
   end
   assign cfgOut = cfg;

   // source select and prescaler
   logic srcEdge;
   logic pwmTick;
   assign srcEdge = cfg.useMainClk ? mainClkEdge : slowEdge;

   lpw_prescale #(.PRE_W(PRE_W)) u_pre (
      .sys_clk(sys_clk),
      .rst_b(rst_b),
      .clkEn(clkEn),
      .srcEdge(srcEdge),
      .prescale(cfg.prescale),
      .tick(pwmTick)
   );

   lpw_watchdog #(.WDT_W(LPW_WDT_W)) u_wdt (
      .sys_clk(sys_clk),
      .rst_b(rst_b),
      .clkEn(clkEn),
      .active(wdtActive),
      .reload(wrIn.cfgWrite | wrIn.dutyWrite),
      .reloadValue(wrIn.cfgWrite ? cfgIn.watchdog_reload_value : cfg.watchdog_reload_value),
      .tick5(tick5),
      .count(wdtCount),
      .terminal(wdtTerminal)
   );
   assign wdtIrq = wdtTerminal;

   // 256-step phase counter and output compare
   logic [LPW_DUTY_W-1:0] phase;
   logic [LPW_DUTY_W-1:0] next_phase;
   logic next_pwmOut;

   always_comb begin
      next_phase = phase;
      if (pwmTick) begin
         next_phase = phase + 1'b1;
      end
      case (cfg.control)
         LPW_CTRL_OFF: next_pwmOut = 1'b0;
         LPW_CTRL_PWM: next_pwmOut = phase < duty;
         LPW_CTRL_FULL_ON: next_pwmOut = 1'b1;
         default: next_pwmOut = 1'b1;
      endcase
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         phase <= '0;
         pwmOut <= 1'b0;
      end else if (clkEn) begin
         phase <= next_phase;
         pwmOut <= next_pwmOut;
      end
   end

   // checks
   property p_reset_load;
      @(posedge sys_clk) $rose(rst_b) |-> wdtCount == LPW_WDT_RESET_LOAD;
   endproperty
   a_reset_load: assert property (p_reset_load) else $error("bad reset load");

   property p_reload;
      @(posedge sys_clk) disable iff (!rst_b)
         clkEn && wrIn.dutyWrite && !wrIn.cfgWrite |=> wdtCount == $past(cfg.watchdog_reload_value);
   endproperty
   a_reload: assert property (p_reload) else $error("no reload on duty write");

   property p_dec;
      @(posedge sys_clk) disable iff (!rst_b)
         clkEn && tick5 && wdtActive && wdtCount != 8'h00 && !wrIn.cfgWrite && !wrIn.dutyWrite
         |=> wdtCount == $past(wdtCount) - 8'h01;
   endproperty
   a_dec: assert property (p_dec) else $error("no decrement");

   property p_hold;
      @(posedge sys_clk) disable iff (!rst_b)
         clkEn && !tick5 && !wrIn.cfgWrite && !wrIn.dutyWrite |=> $stable(wdtCount);
   endproperty
   a_hold: assert property (p_hold) else $error("counter moved without tick");

   property p_force;
      @(posedge sys_clk) disable iff (!rst_b)
         clkEn && wdtTerminal |=> cfg.control == LPW_CTRL_FULL_ON ##2 pwmOut;
   endproperty
   a_force: assert property (p_force) else $error("not forced full on");

   property p_others;
      @(posedge sys_clk) disable iff (!rst_b)
         clkEn && wdtTerminal && !wrIn.cfgWrite && !wrIn.dutyWrite
         |=> $stable(cfg.prescale) && $stable(duty) && $stable(cfg.watchdog_reload_value);
   endproperty
   a_others: assert property (p_others) else $error("other field changed");

   property p_pulse;
      @(posedge sys_clk) disable iff (!rst_b) clkEn && wdtIrq |=> !wdtIrq;
   endproperty
   a_pulse: assert property (p_pulse) else $error("irq not a pulse");

   property p_disabled;
      @(posedge sys_clk) disable iff (!rst_b)
         clkEn && !wdtActive && !wrIn.cfgWrite && !wrIn.dutyWrite |=> !wdtIrq;
   endproperty
   a_disabled: assert property (p_disabled) else $error("irq while disabled");

   property p_duty;
      @(posedge sys_clk) disable iff (!rst_b)
         clkEn && $stable(cfg.control) && cfg.control == LPW_CTRL_PWM && duty == 8'h00 |=> !pwmOut;
   endproperty
   a_duty: assert property (p_duty) else $error("zero duty drove high");

   property p_cfg_reload;
      @(posedge sys_clk) disable iff (!rst_b)
         clkEn && wrIn.cfgWrite |=> wdtCount == $past(cfgIn.watchdog_reload_value);
   endproperty
   a_cfg_reload: assert property (p_cfg_reload) else $error("no reload on config write");

   property p_duty_take;
      @(posedge sys_clk) disable iff (!rst_b)
         clkEn && wrIn.dutyWrite |=> duty == $past(wrIn.duty);
   endproperty
   a_duty_take: assert property (p_duty_take) else $error("duty write not taken");

   property p_no_rise;
      @(posedge sys_clk) disable iff (!rst_b)
         clkEn && !wrIn.cfgWrite && !wrIn.dutyWrite |=> wdtCount <= $past(wdtCount);
   endproperty
   a_no_rise: assert property (p_no_rise) else $error("counter reloaded by itself");

   property p_zero_hold;
      @(posedge sys_clk) disable iff (!rst_b)
         clkEn && wdtCount == 8'h00 && !wrIn.cfgWrite && !wrIn.dutyWrite |=> wdtCount == 8'h00;
   endproperty
   a_zero_hold: assert property (p_zero_hold) else $error("zero counter moved");

   property p_irq_step;
      @(posedge sys_clk) disable iff (!rst_b)
         $rose(wdtIrq) |-> $past(wdtCount) == 8'h01 && wdtCount == 8'h00;
   endproperty
   a_irq_step: assert property (p_irq_step) else $error("irq without 1 to 0 step");

   property p_irq_active;
      @(posedge sys_clk) disable iff (!rst_b)
         $rose(wdtIrq) |-> $past(wdtActive);
   endproperty
   a_irq_active: assert property (p_irq_active) else $error("irq from inactive watchdog");

   property p_no_irq_idle;
      @(posedge sys_clk) disable iff (!rst_b)
         clkEn && wdtCount == 8'h00 && !wrIn.cfgWrite && !wrIn.dutyWrite |=> !wdtIrq;
   endproperty
   a_no_irq_idle: assert property (p_no_irq_idle) else $error("irq repeated at zero");

   property p_full_level;
      @(posedge sys_clk) disable iff (!rst_b)
         clkEn && cfg.control == LPW_CTRL_FULL_ON |=> pwmOut;
   endproperty
   a_full_level: assert property (p_full_level) else $error("full on not high");

   property p_force_stay;
      @(posedge sys_clk) disable iff (!rst_b)
         clkEn && cfg.control == LPW_CTRL_FULL_ON && !wrIn.cfgWrite |=> cfg.control == LPW_CTRL_FULL_ON;
   endproperty
   a_force_stay: assert property (p_force_stay) else $error("forced control lost");

   property p_phase;
      @(posedge sys_clk) disable iff (!rst_b)
         clkEn && pwmTick |=> phase == $past(phase) + 8'h01;
   endproperty
   a_phase: assert property (p_phase) else $error("phase did not step");

   property p_phase_hold;
      @(posedge sys_clk) disable iff (!rst_b)
         clkEn && !pwmTick |=> $stable(phase);
   endproperty
   a_phase_hold: assert property (p_phase_hold) else $error("phase moved without tick");

   property p_tick_src;
      @(posedge sys_clk) disable iff (!rst_b)
         $past(clkEn) && pwmTick |-> $past(srcEdge);
   endproperty
   a_tick_src: assert property (p_tick_src) else $error("tick without source edge");

   property p_freeze;
      @(posedge sys_clk) disable iff (!rst_b)
         !clkEn |=> $stable(cfg) && $stable(duty) && $stable(wdtCount) && $stable(pwmOut);
   endproperty
   a_freeze: assert property (p_freeze) else $error("state moved while frozen");

   c_irq: cover property (@(posedge sys_clk) disable iff (!rst_b) wdtIrq);
   c_tick: cover property (@(posedge sys_clk) disable iff (!rst_b) pwmTick && phase == 8'hff);
   c_high: cover property (@(posedge sys_clk) disable iff (!rst_b) pwmOut && cfg.control == LPW_CTRL_PWM);
   c_force: cover property (@(posedge sys_clk) disable iff (!rst_b)
      cfg.control == LPW_CTRL_FULL_ON && wdtCount == 8'h00);
   c_blink: cover property (@(posedge sys_clk) disable iff (!rst_b) pwmTick && !cfg.useMainClk);
endmodule // lpw_top

/* File: test/lpw_led_driver.sv */
// led driver model: measures high time and period of the pwm output
`timescale 1ns/10ps
module lpw_led_driver (
   input wire logic sys_clk,
   input wire logic pwmOut,
   output logic [15:0] highLen,
   output logic [15:0] periodLen,
   output int rises
);
   logic prev = 1'b0;
   logic [15:0] hiCnt = 16'h0;
   logic [15:0] perCnt = 16'h0;
   initial begin
      highLen = 16'h0;
      periodLen = 16'h0;
      rises = 0;
   end
   // a period runs from one rising edge to the next
   always @(posedge sys_clk) begin
      prev <= pwmOut;
      if (pwmOut === 1'b1 && prev === 1'b0) begin
         periodLen <= perCnt;
         highLen <= hiCnt;
         perCnt <= 16'h1;
         hiCnt <= 16'h1;
         rises <= rises + 1;
      end else begin
         perCnt <= perCnt + 16'h1;
         hiCnt <= hiCnt + {15'h0, pwmOut === 1'b1};
      end
   end
endmodule // lpw_led_driver

/* File: test/tb.sv */
// testbench: reset, watchdog and pwm scenarios for the led pwm
`timescale 1ns/10ps
module tb;
   import lpw_pkg::*;
   logic sys_clk = 1'b0;
   logic rst_b = 1'b0;
   logic tick5Pin = 1'b0;
   logic clkEn = 1'b1;
   logic mainClkEdge = 1'b1;
   logic slowClkPin = 1'b0;
   lpw_cfg_s cfgIn = '0;
   lpw_wr_s wrIn = '0;
   lpw_cfg_s cfgOut;
   logic [7:0] duty;
   logic [7:0] wdtCount;
   logic wdtIrq;
   logic pwmOut;
   logic [15:0] highLen;
   logic [15:0] periodLen;
   int rises;
   int bad_count = 0;
   int compares = 0;
   int irqs = 0;
   always #20 sys_clk = ~sys_clk;
   always @(posedge sys_clk) if (wdtIrq === 1'b1) irqs <= irqs + 1;
   lpw_top i_lpw_top (.sys_clk(sys_clk), .rst_b(rst_b), .clkEn(clkEn), .mainClkEdge(mainClkEdge),
      .slowClkPin(slowClkPin), .tick5Pin(tick5Pin), .cfgIn(cfgIn), .wrIn(wrIn), .cfgOut(cfgOut), .duty(duty),
      .wdtCount(wdtCount), .wdtIrq(wdtIrq), .pwmOut(pwmOut));
   lpw_led_driver i_lpw_led_driver (.sys_clk(sys_clk), .pwmOut(pwmOut), .highLen(highLen),
      .periodLen(periodLen), .rises(rises));
   task automatic step(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic end_sim;
      $display("compares=%0d mismatches=%0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task automatic wr_cfg(input logic [1:0] ctl, input logic [11:0] pre, input logic [7:0] ld, input logic m);
      cfgIn = lpw_cfg_s'{ctl, m, pre, ld};
      wrIn.cfgWrite = 1'b1;
      step(1);
      wrIn.cfgWrite = 1'b0;
      step(2);
   endtask
   task automatic wr_duty(input logic [7:0] d);
      wrIn.duty = d;
      wrIn.dutyWrite = 1'b1;
      step(1);
      wrIn.dutyWrite = 1'b0;
      step(2);
   endtask
   task automatic tick(input int n);
      repeat (n) begin
         tick5Pin = 1'b1;
         step(3);
         tick5Pin = 1'b0;
         step(3);
      end
   endtask
   task automatic t_reset;
      cmp(wdtCount, 8'h14);
      cmp(cfgOut.watchdog_reload_value, 8'h14);
      cmp({duty, pwmOut, wdtIrq}, 10'h0);
      $display("test reset done");
   endtask
   task automatic t_wdt;
      int i0;
      wr_cfg(LPW_CTRL_PWM, 12'h005, 8'h03, 1'b1);
      cmp(wdtCount, 8'h03);
      tick(1);
      cmp(wdtCount, 8'h02);
      wr_duty(8'h40);
      cmp(wdtCount, 8'h03);
      tick(1);
      step(50);
      cmp(wdtCount, 8'h02);
      i0 = irqs;
      tick(1);
      cmp(wdtCount, 8'h01);
      tick(1);
      cmp(irqs - i0, 1);
      cmp(cfgOut, lpw_cfg_s'{LPW_CTRL_FULL_ON, 1'b1, 12'h005, 8'h03});
      cmp({duty, pwmOut}, {8'h40, 1'b1});
      tick(2);
      cmp(wdtCount, 8'h00);
      cmp(irqs - i0, 1);
      $display("test watchdog done");
   endtask
   task automatic t_gate;
      int i0;
      i0 = irqs;
      wr_cfg(LPW_CTRL_OFF, 12'h000, 8'h01, 1'b0);
      tick(2);
      cmp({wdtCount, pwmOut}, {8'h01, 1'b0});
      wr_cfg(LPW_CTRL_OFF, 12'h000, 8'h00, 1'b1);
      tick(2);
      cmp({cfgOut.control, wdtCount}, 10'h0);
      cmp(irqs - i0, 0);
      $display("test gating done");
   endtask
   task automatic t_pwm;
      logic [11:0] pre [3] = '{12'h000, 12'h001, 12'h000};
      logic [7:0] dut [3] = '{8'h40, 8'h40, 8'hff};
      int r0;
      int k;
      wr_cfg(LPW_CTRL_ON_ALT, 12'h000, 8'h00, 1'b1);
      step(2);
      cmp(pwmOut, 1'b1);
      for (int i = 0; i < 3; i++) begin
         wr_cfg(LPW_CTRL_PWM, pre[i], 8'h00, 1'b1);
         wr_duty(dut[i]);
         r0 = rises;
         k = 0;
         while (rises - r0 < 3 && k < 3000) begin
            step(1);
            k++;
         end
         if (k >= 3000) begin
            bad_count++;
            return;
         end
         cmp(periodLen, 32'd256 * (pre[i] + 1));
         cmp(highLen, dut[i] * (pre[i] + 32'd1));
      end
      $display("test pwm done");
   endtask
   task automatic t_blink;
      int r0;
      int k;
      wr_cfg(LPW_CTRL_PWM, 12'h000, 8'h00, 1'b0);
      wr_duty(8'h40);
      r0 = rises;
      k = 0;
      while (rises - r0 < 3 && k < 4000) begin
         if (k % 2 == 0) slowClkPin = ~slowClkPin;
         step(1);
         k++;
      end
      slowClkPin = 1'b0;
      if (k >= 4000) begin
         bad_count++;
         return;
      end
      // slow pin period is four clocks: one source edge per four clocks
      cmp(periodLen, 32'd4 * 32'd256);
      cmp(highLen, 32'd4 * 32'h40);
      $display("test blink done");
   endtask
   task automatic t_freeze;
      wr_cfg(LPW_CTRL_PWM, 12'h000, 8'h05, 1'b1);
      clkEn = 1'b0;
      tick(1);
      wr_duty(8'h22);
      cmp({duty, wdtCount}, {8'h40, 8'h05});
      clkEn = 1'b1;
      tick(1);
      cmp(wdtCount, 8'h04);
      $display("test freeze done");
   endtask
   initial begin
      step(20);
      rst_b = 1'b1;
      step(2);
      t_reset();
      t_wdt();
      t_gate();
      t_pwm();
      t_blink();
      t_freeze();
      end_sim();
   end
endmodule // tb
